// ### hw/asl_map.svh
// Offsets, field positions, reset values and timing figures of the
// axis status LED block. Assumes a 250 MHz module clock.
`ifndef ASL_MAP_SVH
`define ASL_MAP_SVH

// Clock rate in MHz
`define ASL_CLK_MHZ 250
// Half period of the shared blink, in ms
`define ASL_BLINK_HALF_MS 250
// Encoder activity window, in ms
`define ASL_ENC_WIN_MS 100

// Register byte offsets
`define ASL_OFF_CTRL 8'h00
`define ASL_OFF_STATUS 8'h04
`define ASL_OFF_IRQ_STAT 8'h08
`define ASL_OFF_IRQ_MASK 8'h0C

// Control fields and reset value
`define ASL_CTRL_ENC1_EN 0
`define ASL_CTRL_LAMP_TEST 1
`define ASL_CTRL_RST 2'h1

// Event bits of status and mask
`define ASL_EVT_FAULT 0
`define ASL_EVT_LIMIT 1
`define ASL_EVT_ENC 2
`define ASL_EVT_SUP_LOST 3

// LED indices
`define ASL_LED_AXIS 0
`define ASL_LED_ENC 1
`define ASL_LED_LIMIT 2
`define ASL_LED_FAULT 3

`endif

// ### hw/asl_pkg.sv
// Types shared by the axis status LED block.
// Assumes the map header is on the include path.
package asl_pkg;

  // LED drive modes, Gray coded off -> blink -> on
  typedef enum logic [1:0] {
    ASL_LED_OFF = 2'b00,
    ASL_LED_BLINK = 2'b01,
    ASL_LED_ON = 2'b11
  } asl_led_mode_t;

  // Internal module state seen by the indicators
  typedef struct packed {
    logic sleep;
    logic booted;
    logic drv_en;
    logic supply;
    logic fwd_lim;
    logic rev_lim;
    logic home;
    logic [7:0] fault;
  } asl_sys_in_t;

  // State of the blink divider
  typedef struct packed {
    logic [31:0] cnt;
    logic phase;
  } asl_div_state_t;

  // State of the main block
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [1:0] ctrl;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [31:0] enc_cnt;
    logic [3:0] prev;
    logic [3:0] led;
  } asl_state_t;

endpackage

// ### hw/asl_blink_div.sv
// Free-running divider giving the shared blink phase.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module asl_blink_div
  import asl_pkg::*;
#(
  parameter int unsigned HALF_CYC = 32'd62500000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Blink phase, toggles every HALF_CYC cycles
  output logic phase_o
);

  asl_div_state_t s_q;
  asl_div_state_t s_d;

  // Count down, toggle phase on terminal count
  always_comb begin
    s_d = s_q;
    if (s_q.cnt == 32'h0) begin
      s_d.cnt = HALF_CYC - 32'h1;
      s_d.phase = ~s_q.phase;
    end else begin
      s_d.cnt = s_q.cnt - 32'h1;
    end
    if (rst_i) begin
      s_d = '0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign phase_o = s_q.phase;

endmodule

`default_nettype wire

// ### hw/asl_status_led.sv
// Axis status LED logic with a classic Wishbone register slave.
// Assumes all inputs synchronous to clk_i; encoder edges are
// one-cycle pulses from the encoder front end.
//
// Function
// - Four separate LEDs: axis, encoder, limit, fault
// - Axis LED dark asleep or unbooted
// - Axis LED blinks when booted, drive disabled
// - Axis LED steady on with drive enabled
// - Encoder LED dark without external supply
// - Encoder LED blinks with supply and pulses
// - Blink rate fixed, not pulse rate
// - Either encoder's pulses make it blink
// - Encoder LED on with supply, no pulses
// - Limit LED dark without supply or inputs
// - Limit LED on with supply and input
// - Fault LED on while any fault present
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`include "asl_map.svh"
`timescale 1ns/10ps
`default_nettype none

module asl_status_led
  import asl_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYC =
    `ASL_BLINK_HALF_MS * `ASL_CLK_MHZ * 1000,
  parameter int unsigned ENC_WIN_CYC =
    `ASL_ENC_WIN_MS * `ASL_CLK_MHZ * 1000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Module state
  input wire asl_sys_in_t sys_i,
  input wire logic [1:0] enc_edge_i,
  // Front-panel LEDs
  output logic led_axis_o,
  output logic led_enc_o,
  output logic led_limit_o,
  output logic led_fault_o,
  // Interrupt
  output logic irq_o
);

  // ************************************************************
  // Declarations
  // ************************************************************

  asl_state_t s_q;
  asl_state_t s_d;
  logic blink_w;
  logic [1:0] enc_en_w;
  logic [1:0] enc_hit_w;
  logic enc_act_w;
  logic limit_w;
  logic fault_w;
  logic bus_req_w;
  logic rd_clr_w;
  logic [3:0] now_w;
  logic [3:0] evt_w;
  logic [31:0] rd_w;
  asl_led_mode_t [3:0] mode_w;

  // ************************************************************
  // Blink source
  // ************************************************************

  asl_blink_div #(
    .HALF_CYC(BLINK_HALF_CYC)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .phase_o(blink_w)
  );

  // ************************************************************
  // Input qualification
  // ************************************************************

  // Secondary encoder only counts while the ASL_CTRL_ENC1_EN control bit is set
  assign enc_en_w = {s_q.ctrl[`ASL_CTRL_ENC1_EN], 1'b1};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_enc
      assign enc_hit_w[g] = enc_edge_i[g] & enc_en_w[g];
    end
  endgenerate

  assign enc_act_w = (s_q.enc_cnt != 32'h0);

  // Any limit or home input, gated by supply
  assign limit_w = sys_i.supply &
    (sys_i.fwd_lim | sys_i.rev_lim | sys_i.home);

  // Any module fault
  assign fault_w = |sys_i.fault;

  // ************************************************************
  // LED mode selection
  // ************************************************************

  // Per-LED mode from the module state
  always_comb begin
    if (sys_i.sleep || !sys_i.booted) begin
      mode_w[`ASL_LED_AXIS] = ASL_LED_OFF;
    end else if (sys_i.drv_en) begin
      mode_w[`ASL_LED_AXIS] = ASL_LED_ON;
    end else begin
      mode_w[`ASL_LED_AXIS] = ASL_LED_BLINK;
    end

    if (!sys_i.supply) begin
      mode_w[`ASL_LED_ENC] = ASL_LED_OFF;
    end else if (enc_act_w) begin
      mode_w[`ASL_LED_ENC] = ASL_LED_BLINK;
    end else begin
      mode_w[`ASL_LED_ENC] = ASL_LED_ON;
    end

    if (limit_w) begin
      mode_w[`ASL_LED_LIMIT] = ASL_LED_ON;
    end else begin
      mode_w[`ASL_LED_LIMIT] = ASL_LED_OFF;
    end

    if (fault_w) begin
      mode_w[`ASL_LED_FAULT] = ASL_LED_ON;
    end else begin
      mode_w[`ASL_LED_FAULT] = ASL_LED_OFF;
    end
  end

  // ************************************************************
  // Event detection
  // ************************************************************

  // Current levels, same layout as the event bits
  always_comb begin
    now_w = 4'h0;
    now_w[`ASL_EVT_FAULT] = fault_w;
    now_w[`ASL_EVT_LIMIT] = limit_w;
    now_w[`ASL_EVT_ENC] = enc_act_w;
    now_w[`ASL_EVT_SUP_LOST] = sys_i.supply;
  end

  // Rising edges, except supply which reports its loss
  always_comb begin
    evt_w = now_w & ~s_q.prev;
    evt_w[`ASL_EVT_SUP_LOST] = s_q.prev[`ASL_EVT_SUP_LOST] &
      ~sys_i.supply;
  end

  // ************************************************************
  // Register read mux
  // ************************************************************

  // New request, one per cycle of ack low
  assign bus_req_w = wb_cyc_i & wb_stb_i & ~s_q.ack;

  // Status read clears the sticky bits it returns
  assign rd_clr_w = bus_req_w & ~wb_we_i &
    (wb_adr_i == `ASL_OFF_IRQ_STAT);

  // Unmapped addresses read as zero
  always_comb begin
    rd_w = 32'h0;
    unique case (wb_adr_i)
      `ASL_OFF_CTRL: begin
        rd_w[1:0] = s_q.ctrl;
      end
      `ASL_OFF_STATUS: begin
        rd_w[3:0] = s_q.led;
        rd_w[11:4] = mode_w;
        rd_w[12] = enc_act_w;
        rd_w[13] = blink_w;
      end
      `ASL_OFF_IRQ_STAT: begin
        rd_w[3:0] = s_q.irq_stat;
      end
      `ASL_OFF_IRQ_MASK: begin
        rd_w[3:0] = s_q.irq_mask;
      end
      default: begin
        rd_w = 32'h0;
      end
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************

  // Bus, window, sticky bits and LED drive
  always_comb begin
    s_d = s_q;

    // Ack for one cycle, then drop so a held strobe is not
    // taken twice
    s_d.ack = bus_req_w;
    if (bus_req_w && !wb_we_i) begin
      s_d.dat = rd_w;
    end

    // Writes land in the low byte lane only
    if (bus_req_w && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == `ASL_OFF_CTRL) begin
        s_d.ctrl = wb_dat_i[1:0];
      end
      if (wb_adr_i == `ASL_OFF_IRQ_MASK) begin
        s_d.irq_mask = wb_dat_i[3:0];
      end
    end

    if (|enc_hit_w) begin
      s_d.enc_cnt = ENC_WIN_CYC;
    end else if (enc_act_w) begin
      s_d.enc_cnt = s_q.enc_cnt - 32'h1;
    end

    // Set wins over the read clear in the same cycle
    s_d.irq_stat = s_q.irq_stat;
    if (rd_clr_w) begin
      s_d.irq_stat = 4'h0;
    end
    s_d.irq_stat = s_d.irq_stat | evt_w;
    s_d.prev = now_w;

    for (int i = 0; i < 4; i++) begin
      unique case (mode_w[i])
        ASL_LED_OFF: s_d.led[i] = 1'b0;
        ASL_LED_BLINK: s_d.led[i] = blink_w;
        ASL_LED_ON: s_d.led[i] = 1'b1;
        default: s_d.led[i] = 1'b0;
      endcase
    end

    // Lamp test lights every LED for panel checks
    if (s_q.ctrl[`ASL_CTRL_LAMP_TEST]) begin
      s_d.led = 4'hF;
    end

    // Synchronous reset
    if (rst_i) begin
      s_d = '0;
      s_d.ctrl = `ASL_CTRL_RST;
    end
  end

  // ************************************************************
  // State register and outputs
  // ************************************************************

  // Single state register
  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  // Bus answer
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.dat;

  // LED pins
  assign led_axis_o = s_q.led[`ASL_LED_AXIS];
  assign led_enc_o = s_q.led[`ASL_LED_ENC];
  assign led_limit_o = s_q.led[`ASL_LED_LIMIT];
  assign led_fault_o = s_q.led[`ASL_LED_FAULT];

  // Level interrupt from unmasked sticky bits
  assign irq_o = |(s_q.irq_stat & s_q.irq_mask);

endmodule

`default_nettype wire

// ### verif/asl_status_led_properties.sv
// Port checker for the status LED block.
// Assumes a bind to asl_status_led with short blink and window counts.
`timescale 1ns/10ps
`default_nettype none
module asl_status_led_chk
  import asl_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYC = 8,
  parameter int unsigned ENC_WIN_CYC = 20
) (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Module state and LEDs
  input wire asl_sys_in_t sys_i,
  input wire logic [1:0] enc_edge_i,
  input wire logic led_axis_o,
  input wire logic led_enc_o,
  input wire logic led_limit_o,
  input wire logic led_fault_o
);
  localparam int BLK = 2 * BLINK_HALF_CYC + 2;
  localparam int ENW = ENC_WIN_CYC + 4;
  logic rst_d, lamp_q, enc1_q;
  logic [31:0] idle_q;
  wire run_c = !sys_i.sleep && sys_i.booted;
  wire lim_c = sys_i.supply && (sys_i.fwd_lim || sys_i.rev_lim || sys_i.home);
  // Lamp test overrides every LED, so track it
  always_ff @(posedge clk_i) begin
    rst_d <= rst_i;
    // Control lands at the edge the request is taken
    if (rst_i) begin
      lamp_q <= 1'b0;
      enc1_q <= 1'b1;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h00
        && wb_sel_i[0]) begin
      lamp_q <= wb_dat_i[1];
      enc1_q <= wb_dat_i[0];
    end
    // Secondary edges only count while that encoder is enabled
    if (rst_i || enc_edge_i[0] || (enc_edge_i[1] && enc1_q)) idle_q <= 32'h0;
    else if (idle_q < 32'hFFFF) idle_q <= idle_q + 32'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || rst_d);
  a_axis_dark: assert property (!lamp_q && !run_c |=> !led_axis_o)
    else $error("axis LED lit while not running");
  a_axis_blinks: assert property (!lamp_q && run_c && !sys_i.drv_en |->
    ##[1:BLK] ($changed(led_axis_o) || lamp_q || !run_c || sys_i.drv_en))
    else $error("axis LED not blinking");
  a_axis_on: assert property (!lamp_q && run_c && sys_i.drv_en |=> led_axis_o)
    else $error("axis LED dark with drive on");
  a_enc_dark: assert property (!lamp_q && !sys_i.supply |=> !led_enc_o)
    else $error("encoder LED lit without supply");
  a_enc_blinks: assert property (!lamp_q && sys_i.supply && idle_q < 2 |->
    ##[1:BLK] ($changed(led_enc_o) || lamp_q || !sys_i.supply))
    else $error("encoder LED not blinking");
  a_enc_steady: assert property (!lamp_q && sys_i.supply && idle_q > ENW |=> led_enc_o)
    else $error("encoder LED dark while idle");
  a_limit_led: assert property (!lamp_q |=> led_limit_o == $past(lim_c))
    else $error("limit LED wrong");
  a_fault_led: assert property (!lamp_q |=> led_fault_o == $past(|sys_i.fault))
    else $error("fault LED wrong");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  c_axis_on: cover property (run_c && led_axis_o);
  c_enc_blink: cover property (sys_i.supply && idle_q < 2 && $fell(led_enc_o));
  c_bus_write: cover property (wb_ack_o && wb_we_i);
endmodule
bind asl_status_led asl_status_led_chk #(.BLINK_HALF_CYC(BLINK_HALF_CYC),
  .ENC_WIN_CYC(ENC_WIN_CYC)) chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .sys_i(sys_i), .enc_edge_i(enc_edge_i),
  .led_axis_o(led_axis_o), .led_enc_o(led_enc_o), .led_limit_o(led_limit_o),
  .led_fault_o(led_fault_o));
`default_nettype wire

// ### verif/asl_led_watch.sv
// Operator's eye on the panel: records levels seen since a clear.
// Assumes the bench clears it before each look.
`timescale 1ns/10ps
`default_nettype none
module asl_led_watch (
  // Clock and clear
  input wire logic clk_i,
  input wire logic clr_i,
  // LEDs, bit 0 axis up to bit 3 fault
  input wire logic [3:0] led_i,
  // Lit and dark seen; both means blinking
  output logic [3:0] hi_o,
  output logic [3:0] lo_o
);
  always_ff @(posedge clk_i) begin
    hi_o <= clr_i ? 4'h0 : hi_o | led_i;
    lo_o <= clr_i ? 4'h0 : lo_o | ~led_i;
  end
endmodule
`default_nettype wire

// ### verif/asl_status_led_tb_top.sv
// Bench for the status LED block: bus tasks and LED looks.
// Assumes short blink (8) and window (20) counts.
`timescale 1ns/10ps
`default_nettype none
module asl_status_led_tb_top;
  import asl_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic wb_ack, irq, clr = 1'b0, pulse_en = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r, rdat;
  logic [1:0] enc = 2'h0, pmask = 2'h1;
  logic [2:0] pcnt = 3'h0;
  logic [3:0] led, hi, lo;
  asl_sys_in_t sys = '0;
  int n_errors = 0, n_tests = 0, cyc_cnt = 0;
  always #2 clk_i = ~clk_i;
  asl_status_led #(.BLINK_HALF_CYC(8), .ENC_WIN_CYC(20)) dut_u (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_sel_i(4'hF),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
    .sys_i(sys), .enc_edge_i(enc), .led_axis_o(led[0]), .led_enc_o(led[1]),
    .led_limit_o(led[2]), .led_fault_o(led[3]), .irq_o(irq));
  asl_led_watch eye_u (.clk_i(clk_i), .clr_i(clr), .led_i(led), .hi_o(hi), .lo_o(lo));
  // Encoder pulses every 8 cycles, well inside the window; hang guard
  always @(posedge clk_i) begin
    pcnt <= pcnt + 3'h1;
    enc <= (pulse_en && pcnt == 3'h0) ? pmask : 2'h0;
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= d;
    // Only the cycle ceiling ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rdat = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb_xfer(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask
  // Settle, then watch 40 cycles: off = lo only, on = hi only, blink = both
  task automatic look(input logic [3:0] ehi, input logic [3:0] elo);
    repeat (30) @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (40) @(posedge clk_i);
    check({24'h0, hi, lo}, {24'h0, ehi, elo});
  endtask
  task automatic finish_test;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h00, 32'h1);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h0);
    wb_xfer(1'b1, 8'h0C, 32'h1);
    rd(8'h0C, 32'h1);
    $display("registers done");
    sys.sleep <= 1'b1;
    sys.booted <= 1'b1;
    look(4'b0000, 4'b1111);
    sys.sleep <= 1'b0;
    look(4'b0001, 4'b1111);
    sys.drv_en <= 1'b1;
    look(4'b0001, 4'b1110);
    sys.supply <= 1'b1;
    look(4'b0011, 4'b1100);
    for (int i = 1; i < 3; i++) begin
      pmask <= i[1:0];
      pulse_en <= 1'b1;
      look(4'b0011, 4'b1110);
    end
    wb_xfer(1'b1, 8'h00, 32'h0);
    look(4'b0011, 4'b1100);
    wb_xfer(1'b1, 8'h00, 32'h3);
    look(4'b1111, 4'b0000);
    wb_xfer(1'b1, 8'h00, 32'h1);
    rd(8'h00, 32'h1);
    pulse_en <= 1'b0;
    $display("axis and encoder done");
    for (int i = 0; i < 3; i++) begin
      {sys.fwd_lim, sys.rev_lim, sys.home} <= 3'b100 >> i;
      look(4'b0111, 4'b1000);
    end
    sys.supply <= 1'b0;
    look(4'b0001, 4'b1110);
    sys.supply <= 1'b1;
    sys.home <= 1'b0;
    rd(8'h0C, 32'h1);
    wb_xfer(1'b0, 8'h08, 32'h0);
    sys.fault <= 8'h80;
    look(4'b1011, 4'b0100);
    check({31'h0, irq}, 32'h1);
    wb_xfer(1'b0, 8'h08, 32'h0);
    check(rdat & 32'h1, 32'h1);
    check({31'h0, irq}, 32'h0);
    wb_xfer(1'b1, 8'h0C, 32'h0);
    sys.fault <= 8'h00;
    look(4'b0011, 4'b1100);
    sys.fault <= 8'h01;
    repeat (4) @(posedge clk_i);
    check({31'h0, irq}, 32'h0);
    rd(8'h08, 32'h1);
    rd(8'h08, 32'h0);
    $display("limit, fault and interrupt done");
    finish_test();
  end
endmodule
`default_nettype wire
